// file: core/fcs_busy_timer.sv
`timescale 1ns/1ps
module fcs_busy_timer #(
  parameter int CW = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic [CW-1:0] cycles,
  // Status
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic busy;
    logic done;
  } fcs_tmr_t;

  fcs_tmr_t st_reg;
  fcs_tmr_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (st_reg.busy) begin
      if (st_reg.cnt <= CW'(1)) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt - CW'(1);
      end
    end else if (start) begin
      st_next.busy = 1'b1;
      st_next.cnt = cycles;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = st_reg.busy;
  assign done = st_reg.done;

endmodule : fcs_busy_timer

// file: core/fcs_flash_cfg.svh
`ifndef FCS_FLASH_CFG_SVH
`define FCS_FLASH_CFG_SVH

// Clock rate
`define FCS_CLK_MHZ 125

// Register indices; byte address is four times the index
`define FCS_IDX_MODE_A 12'h220
`define FCS_IDX_MODE_B 12'h221
`define FCS_IDX_MODE_C 12'h222
`define FCS_IDX_MODE_G 12'h230

// Flash array window select bit of the byte address
`define FCS_FLASH_WIN_BIT 15

// Command codes (low byte only)
`define FCS_CMD_READ_ARRAY 8'hff
`define FCS_CMD_READ_STATUS 8'h70
`define FCS_CMD_CLEAR_STATUS 8'h50
`define FCS_CMD_PROGRAM 8'h41
`define FCS_CMD_ERASE 8'h20
`define FCS_CMD_LOCK_QUERY 8'h71
`define FCS_CMD_BLANK 8'h25
`define FCS_CMD_CONFIRM 8'hd0

// Field positions
`define FCS_MODE_A_READY_BIT 0
`define FCS_MODE_B_GUARD_BIT 1
`define FCS_MODE_B_DF_WAIT_BIT 7
`define FCS_STAT_READY_BIT 7
`define FCS_STAT_LOCK_BIT 6
`define FCS_STAT_ERASE_ERR_BIT 5
`define FCS_STAT_PROG_ERR_BIT 4

// Reset values
`define FCS_RST_MODE 8'h00
`define FCS_RST_STATUS 8'h80

// Blocks below this number form the low block range
`define FCS_LOW_BLOCKS 8

// Operation times
`define FCS_PROG_TIME_NS 20000
`define FCS_ERASE_TIME_NS 300000

`endif

// file: core/fcs_flash_seq.sv
// Notes on behaviour
// - Program: command, low word, high word
// - High word is third write, same address
// - Only the low command byte decodes
// - Small memory: one-write read-array, clear-status
// - Large memory: read-array low then high block
// - Large memory: clear-status low then high block
// - Read-status makes next read return status
// - Erase: setup, confirm at block top address
// - Lock query: code, confirm, report lock
// - No erase-all-unlocked command exists
// - Blank check: code, confirm at block
// - Mode B bit 7 selects data-flash wait
// - Mode B bit 1 gates guarded register writes
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "fcs_flash_cfg.svh"
module fcs_flash_seq #(
  parameter bit LARGE_MEM = 1'b0,
  parameter int BLOCKS = 16,
  parameter int BLOCK_WORDS = 4,
  parameter int PROG_CYCLES = (`FCS_PROG_TIME_NS * `FCS_CLK_MHZ + 999) / 1000,
  parameter int ERASE_CYCLES = (`FCS_ERASE_TIME_NS * `FCS_CLK_MHZ + 999) / 1000
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // System
  input wire logic BUS_WAIT_SETTING_BIT,
  output logic FLASH_BUSY
);

  localparam int DEPTH = BLOCKS * BLOCK_WORDS;
  localparam int AW = $clog2(DEPTH);
  localparam int BW = $clog2(BLOCK_WORDS);
  localparam int BKW = $clog2(BLOCKS);
  localparam int MAXC = (PROG_CYCLES > ERASE_CYCLES) ? PROG_CYCLES : ERASE_CYCLES;
  localparam int CW = $clog2(MAXC + 1);
  localparam int WB = `FCS_FLASH_WIN_BIT;

  if (BLOCK_WORDS < 2 || (1 << BW) != BLOCK_WORDS || (1 << BKW) != BLOCKS) begin : g_chk_pow
    $error("Block count and block size must be powers of two");
  end
  if (LARGE_MEM && BLOCKS <= `FCS_LOW_BLOCKS) begin : g_chk_large
    $error("Large memory needs blocks beyond the low range");
  end
  // Lock bits are indexed by three block bits
  if (BLOCKS < `FCS_LOW_BLOCKS) begin : g_chk_lock
    $error("Lock map needs at least the low block range");
  end
  if (AW + 2 > WB || PROG_CYCLES < 1 || ERASE_CYCLES < 1) begin : g_chk_size
    $error("Array exceeds window or zero operation time");
  end

  typedef struct packed {
    fcs_pkg::fcs_seq_t seq;
    fcs_pkg::fcs_op_t op;
    logic [AW-1:0] wa;
    logic [15:0] wd_lo;
    logic [BKW-1:0] blk;
    logic stat_mode;
    logic [7:0] status;
    logic [7:0] mode_a;
    logic [7:0] mode_b;
    logic [7:0] mode_c;
    logic [7:0] mode_g;
    logic dp_wr;
    logic [WB:0] dp_addr;
    logic wait_st;
    logic [31:0] rdata;
    logic [DEPTH-1:0][31:0] mem;
  } fcs_state_t;

  fcs_state_t st_reg;
  fcs_state_t st_next;
  logic tmr_start;
  logic [CW-1:0] tmr_cycles;
  logic tmr_busy;
  logic tmr_done;

  function automatic logic [BKW-1:0] blk_of(input logic [AW-1:0] idx);
    blk_of = idx[AW-1:BW];
  endfunction : blk_of

  function automatic logic is_low(input logic [AW-1:0] idx);
    is_low = (int'(idx[AW-1:BW]) < `FCS_LOW_BLOCKS);
  endfunction : is_low

  function automatic logic is_top(input logic [AW-1:0] idx);
    is_top = &idx[BW-1:0];
  endfunction : is_top

  // Guarded register holds lock bits of the low blocks
  function automatic logic is_locked(input logic [BKW-1:0] b, input logic [7:0] g);
    is_locked = (int'(b) < `FCS_LOW_BLOCKS) ? g[b[2:0]] : 1'b0;
  endfunction : is_locked

  always_comb begin
    logic [7:0] cmd;
    logic [AW-1:0] idx;
    logic [BKW-1:0] b;
    logic [AW-1:0] ridx;
    logic blank;
    cmd = HWDATA[7:0];
    idx = st_reg.dp_addr[AW+1:2];
    b = blk_of(idx);
    ridx = HADDR[AW+1:2];
    blank = 1'b1;
    st_next = st_reg;
    st_next.dp_wr = 1'b0;
    st_next.wait_st = 1'b0;
    tmr_start = 1'b0;
    tmr_cycles = CW'(PROG_CYCLES);
    if (tmr_done) begin
      st_next.seq = fcs_pkg::FCS_SEQ_IDLE;
      st_next.stat_mode = 1'b0;
      st_next.status[`FCS_STAT_READY_BIT] = 1'b1;
    end
    // Data phase of a write
    if (st_reg.dp_wr && st_reg.dp_addr[WB]) begin
      unique case (st_reg.seq)
        fcs_pkg::FCS_SEQ_IDLE: begin
          st_next.stat_mode = 1'b0;
          unique case (cmd)
            `FCS_CMD_READ_ARRAY: begin
              if (LARGE_MEM && is_low(idx)) begin
                st_next.seq = fcs_pkg::FCS_SEQ_RA2;
              end
            end
            `FCS_CMD_READ_STATUS: st_next.stat_mode = 1'b1;
            `FCS_CMD_CLEAR_STATUS: begin
              if (!LARGE_MEM) begin
                st_next.status[`FCS_STAT_ERASE_ERR_BIT] = 1'b0;
                st_next.status[`FCS_STAT_PROG_ERR_BIT] = 1'b0;
              end else if (is_low(idx)) begin
                st_next.seq = fcs_pkg::FCS_SEQ_CS2;
              end
            end
            `FCS_CMD_PROGRAM: begin
              st_next.wa = idx;
              st_next.seq = fcs_pkg::FCS_SEQ_PROG_LO;
            end
            `FCS_CMD_ERASE, `FCS_CMD_LOCK_QUERY, `FCS_CMD_BLANK: begin
              st_next.op = (cmd == `FCS_CMD_ERASE) ? fcs_pkg::FCS_OP_ERASE :
                           (cmd == `FCS_CMD_LOCK_QUERY) ? fcs_pkg::FCS_OP_LOCK :
                           fcs_pkg::FCS_OP_BLANK;
              st_next.blk = b;
              st_next.seq = fcs_pkg::FCS_SEQ_CONFIRM;
            end
            // Erase-all code falls here and is ignored
            default: st_next.stat_mode = 1'b0;
          endcase
        end
        fcs_pkg::FCS_SEQ_RA2: begin
          st_next.seq = fcs_pkg::FCS_SEQ_IDLE;
          if (cmd == `FCS_CMD_READ_ARRAY && !is_low(idx)) begin
            st_next.stat_mode = 1'b0;
          end
        end
        fcs_pkg::FCS_SEQ_CS2: begin
          st_next.seq = fcs_pkg::FCS_SEQ_IDLE;
          if (cmd == `FCS_CMD_CLEAR_STATUS && !is_low(idx)) begin
            st_next.status[`FCS_STAT_ERASE_ERR_BIT] = 1'b0;
            st_next.status[`FCS_STAT_PROG_ERR_BIT] = 1'b0;
          end
        end
        fcs_pkg::FCS_SEQ_PROG_LO: begin
          if (idx == st_reg.wa) begin
            st_next.wd_lo = HWDATA[15:0];
            st_next.seq = fcs_pkg::FCS_SEQ_PROG_HI;
          end else begin
            st_next.status[`FCS_STAT_ERASE_ERR_BIT] = 1'b1;
            st_next.status[`FCS_STAT_PROG_ERR_BIT] = 1'b1;
            st_next.seq = fcs_pkg::FCS_SEQ_IDLE;
          end
        end
        fcs_pkg::FCS_SEQ_PROG_HI: begin
          st_next.seq = fcs_pkg::FCS_SEQ_IDLE;
          if (idx != st_reg.wa) begin
            st_next.status[`FCS_STAT_ERASE_ERR_BIT] = 1'b1;
            st_next.status[`FCS_STAT_PROG_ERR_BIT] = 1'b1;
          end else if (is_locked(b, st_reg.mode_g)) begin
            st_next.status[`FCS_STAT_PROG_ERR_BIT] = 1'b1;
          end else begin
            // Flash cells only clear bits, so AND with old contents
            st_next.mem[idx] = st_reg.mem[idx] & {HWDATA[15:0], st_reg.wd_lo};
            st_next.op = fcs_pkg::FCS_OP_PROG;
            st_next.status[`FCS_STAT_READY_BIT] = 1'b0;
            st_next.seq = fcs_pkg::FCS_SEQ_BUSY;
            tmr_start = 1'b1;
          end
        end
        fcs_pkg::FCS_SEQ_CONFIRM: begin
          st_next.seq = fcs_pkg::FCS_SEQ_IDLE;
          if (cmd != `FCS_CMD_CONFIRM || !is_top(idx) || (LARGE_MEM && b != st_reg.blk)) begin
            st_next.status[`FCS_STAT_ERASE_ERR_BIT] = 1'b1;
            st_next.status[`FCS_STAT_PROG_ERR_BIT] = 1'b1;
          end else if (st_reg.op == fcs_pkg::FCS_OP_LOCK) begin
            st_next.status[`FCS_STAT_LOCK_BIT] = is_locked(b, st_reg.mode_g);
          end else if (st_reg.op == fcs_pkg::FCS_OP_BLANK) begin
            for (int j = 0; j < BLOCK_WORDS; j++) begin
              blank = blank & (&st_reg.mem[int'(b) * BLOCK_WORDS + j]);
            end
            st_next.status[`FCS_STAT_ERASE_ERR_BIT] = !blank;
          end else if (is_locked(b, st_reg.mode_g)) begin
            st_next.status[`FCS_STAT_ERASE_ERR_BIT] = 1'b1;
          end else begin
            for (int j = 0; j < BLOCK_WORDS; j++) begin
              st_next.mem[int'(b) * BLOCK_WORDS + j] = '1;
            end
            st_next.status[`FCS_STAT_READY_BIT] = 1'b0;
            st_next.seq = fcs_pkg::FCS_SEQ_BUSY;
            tmr_start = 1'b1;
            tmr_cycles = CW'(ERASE_CYCLES);
          end
        end
        fcs_pkg::FCS_SEQ_BUSY: st_next.seq = st_next.seq;
        default: st_next.seq = fcs_pkg::FCS_SEQ_IDLE;
      endcase
    end else if (st_reg.dp_wr) begin
      unique case (st_reg.dp_addr[WB-1:2])
        `FCS_IDX_MODE_A: st_next.mode_a = HWDATA[7:0];
        `FCS_IDX_MODE_B: st_next.mode_b = HWDATA[7:0];
        `FCS_IDX_MODE_C: st_next.mode_c = HWDATA[7:0];
        `FCS_IDX_MODE_G: begin
          if (st_reg.mode_b[`FCS_MODE_B_GUARD_BIT]) begin
            st_next.mode_g = HWDATA[7:0];
          end
        end
        default: st_next.dp_wr = 1'b0;
      endcase
    end
    // Address phase
    if (HSEL && HTRANS[1] && HREADY) begin
      st_next.dp_wr = HWRITE;
      st_next.dp_addr = HADDR[WB:0];
      if (!HWRITE) begin
        if (HADDR[WB]) begin
          // Status mode wins over array reads after the next write is seen
          if (st_next.stat_mode || tmr_busy) begin
            st_next.rdata = {24'h0, st_next.status};
            st_next.stat_mode = 1'b0;
          end else begin
            st_next.rdata = st_next.mem[ridx];
          end
          st_next.wait_st = !st_reg.mode_b[`FCS_MODE_B_DF_WAIT_BIT] ||
                            BUS_WAIT_SETTING_BIT;
        end else begin
          unique case (HADDR[WB-1:2])
            `FCS_IDX_MODE_A: begin
              st_next.rdata = {24'h0, st_reg.mode_a};
              st_next.rdata[`FCS_MODE_A_READY_BIT] = !tmr_busy;
            end
            `FCS_IDX_MODE_B: st_next.rdata = {24'h0, st_reg.mode_b};
            `FCS_IDX_MODE_C: st_next.rdata = {24'h0, st_reg.mode_c};
            `FCS_IDX_MODE_G: st_next.rdata = {24'h0, st_reg.mode_g};
            default: st_next.rdata = 32'h0;
          endcase
        end
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_reg <= '0;
      st_reg.seq <= fcs_pkg::FCS_SEQ_IDLE;
      st_reg.status <= `FCS_RST_STATUS;
      st_reg.mode_a <= `FCS_RST_MODE;
      st_reg.mode_b <= `FCS_RST_MODE;
      st_reg.mode_c <= `FCS_RST_MODE;
      st_reg.mode_g <= `FCS_RST_MODE;
      st_reg.mem <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  fcs_busy_timer #(
    .CW(CW)
  ) u_timer (
    .clk(CLK),
    .rst(RST),
    .start(tmr_start),
    .cycles(tmr_cycles),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // One wait cycle at most; slave never errors
  assign HREADYOUT = !st_reg.wait_st;
  assign HRESP = 1'b0;
  assign HRDATA = st_reg.rdata;
  assign FLASH_BUSY = tmr_busy;

endmodule : fcs_flash_seq

// file: core/fcs_pkg.sv
package fcs_pkg;

  // Gray codes along idle -> program -> busy -> confirm path
  typedef enum logic [2:0] {
    FCS_SEQ_IDLE = 3'h0,
    FCS_SEQ_PROG_LO = 3'h1,
    FCS_SEQ_PROG_HI = 3'h3,
    FCS_SEQ_BUSY = 3'h2,
    FCS_SEQ_CONFIRM = 3'h6,
    FCS_SEQ_RA2 = 3'h7,
    FCS_SEQ_CS2 = 3'h5
  } fcs_seq_t;

  typedef enum logic [1:0] {
    FCS_OP_ERASE = 2'h0,
    FCS_OP_LOCK = 2'h1,
    FCS_OP_BLANK = 2'h2,
    FCS_OP_PROG = 2'h3
  } fcs_op_t;

endpackage : fcs_pkg

// file: verif/fcs_host_model.sv
`timescale 1ns/1ps
module fcs_host_model (
  // Bus
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] haddr,
  output logic [31:0] hwdata
);
  assign hsize = 3'h2;
  initial begin
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
  end
  // Read data phase drives inverted junk so stale data cannot pass
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wr ? d : ~hwdata;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask : xfer
  task automatic prog(input logic [31:0] a, input logic [31:0] w);
    logic [31:0] q;
    logic [31:0] wa;
    wa = a & 32'hfffffffc;
    xfer(1'b1, wa, 32'h41, q);
    xfer(1'b1, wa, {16'h0, w[15:0]}, q);
    xfer(1'b1, wa, {16'h0, w[31:16]}, q);
  endtask : prog
  task automatic cmd2(input logic [31:0] a0, input logic [31:0] c0, input logic [31:0] a1,
      input logic [31:0] c1);
    logic [31:0] q;
    xfer(1'b1, a0, c0, q);
    xfer(1'b1, a1, c1, q);
  endtask : cmd2
endmodule : fcs_host_model

// file: verif/fcs_seq_properties.sv
`timescale 1ns/1ps
`include "fcs_flash_cfg.svh"
module fcs_seq_properties #(
  parameter int PROG_CYCLES = 4,
  parameter int ERASE_CYCLES = 8
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  // System
  input wire logic BUS_WAIT_SETTING_BIT,
  input wire logic FLASH_BUSY
);
  localparam int BUSY_MAX = ERASE_CYCLES + PROG_CYCLES + 2;
  logic ap_v, ap_wr, ap_fl, st_pend;
  logic [11:0] ap_idx;
  logic [7:0] b_val, g_val;
  wire take = HSEL & HTRANS[1] & HREADY;
  wire done = ap_v & HREADYOUT;
  wire wr_reg = done & ap_wr & !ap_fl;
  wire rd_reg = done & !ap_wr & !ap_fl;
  wire rd_fl = take & !HWRITE & HADDR[`FCS_FLASH_WIN_BIT];
  wire slow = !b_val[`FCS_MODE_B_DF_WAIT_BIT] | BUS_WAIT_SETTING_BIT;
  // Mirrors kept from bus traffic alone, so readback is judged independently
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ap_v <= 1'b0;
      ap_wr <= 1'b0;
      ap_fl <= 1'b0;
      ap_idx <= 12'h0;
      b_val <= 8'h00;
      g_val <= 8'h00;
      st_pend <= 1'b0;
    end else begin
      if (HREADY) begin
        ap_v <= take;
        ap_wr <= HWRITE;
        ap_fl <= HADDR[`FCS_FLASH_WIN_BIT];
        ap_idx <= HADDR[13:2];
      end
      if (wr_reg && ap_idx == `FCS_IDX_MODE_B)
        b_val <= HWDATA[7:0];
      if (wr_reg && ap_idx == `FCS_IDX_MODE_G && b_val[`FCS_MODE_B_GUARD_BIT])
        g_val <= HWDATA[7:0];
      if (done && ap_fl && ap_wr && !FLASH_BUSY)
        st_pend <= HWDATA[7:0] == `FCS_CMD_READ_STATUS;
      else if (done && ap_fl && !ap_wr)
        st_pend <= 1'b0;
    end
  end
  default clocking dc @(posedge CLK); endclocking
  default disable iff (RST);
  sequence one_wait_s;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  flash_wait_a: assert property (rd_fl && slow |=> one_wait_s)
    else $error("flash read wait missing");
  flash_fast_a: assert property (rd_fl && !slow |=> HREADYOUT)
    else $error("flash read wait unexpected");
  wait_single_a: assert property (!HREADYOUT |=> HREADYOUT)
    else $error("wait longer than one cycle");
  reg_fast_a: assert property (take && !HADDR[15] |=> HREADYOUT)
    else $error("register access waited");
  guard_read_a: assert property (rd_reg && ap_idx == `FCS_IDX_MODE_G |-> HRDATA[7:0] == g_val)
    else $error("guarded register value wrong");
  mode_b_read_a: assert property (rd_reg && ap_idx == `FCS_IDX_MODE_B |-> HRDATA[7:0] == b_val)
    else $error("mode b value wrong");
  status_read_a: assert property (done && !ap_wr && ap_fl && st_pend |-> HRDATA[31:8] == 24'h0)
    else $error("status read returned array data");
  busy_bound_a: assert property ($rose(FLASH_BUSY) |-> ##[1:BUSY_MAX] !FLASH_BUSY)
    else $error("busy never ended");
endmodule : fcs_seq_properties

bind fcs_flash_seq fcs_seq_properties #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES))
  fcs_seq_properties_inst (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .BUS_WAIT_SETTING_BIT(BUS_WAIT_SETTING_BIT), .FLASH_BUSY(FLASH_BUSY));

// file: verif/flash_command_sequencer_bench.sv
`timescale 1ns/1ps
module flash_command_sequencer_bench;
  typedef struct packed {
    logic wr;
    logic bws;
    logic [31:0] a;
    logic [31:0] d;
  } fcs_row_t;
  logic clk, rst, bws, busy, hwrite, hready;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  int err_total = 0;
  int check_count = 0;
  // Reads carry the expected word in d
  fcs_row_t rows [16] = '{
    '{1'b0, 1'b0, 32'h880, 32'h1},
    '{1'b0, 1'b0, 32'h884, 32'h0},
    '{1'b1, 1'b0, 32'h8c0, 32'h1},
    '{1'b0, 1'b0, 32'h8c0, 32'h0},
    '{1'b1, 1'b0, 32'h884, 32'h82},
    '{1'b1, 1'b0, 32'h8c0, 32'h1},
    '{1'b0, 1'b0, 32'h8c0, 32'h1},
    '{1'b1, 1'b0, 32'h8fc, 32'hff},
    '{1'b0, 1'b0, 32'h8fc, 32'h0},
    '{1'b0, 1'b1, 32'h8000, 32'hffffffff},
    '{1'b0, 1'b0, 32'h8000, 32'hffffffff},
    '{1'b1, 1'b0, 32'h8000, 32'ha7},
    '{1'b1, 1'b0, 32'h8000, 32'h1270},
    '{1'b0, 1'b0, 32'h8000, 32'h80},
    '{1'b0, 1'b0, 32'h8000, 32'hffffffff},
    '{1'b1, 1'b0, 32'h884, 32'h2}
  };
  fcs_flash_seq #(.PROG_CYCLES(4), .ERASE_CYCLES(8)) fcs_flash_seq_inst (
    .CLK(clk), .RST(rst), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
    .HRESP(), .BUS_WAIT_SETTING_BIT(bws), .FLASH_BUSY(busy));
  fcs_host_model fcs_host_model_inst (
    .clk(clk), .hready(hready), .hrdata(hrdata), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .haddr(haddr), .hwdata(hwdata));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    fcs_host_model_inst.xfer(1'b0, a, 32'h0, q);
    check(q, e);
  endtask : rd
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    fcs_host_model_inst.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic stat(input logic [31:0] e);
    wr(32'h8000, 32'h70);
    rd(32'h8000, e);
  endtask : stat
  task automatic settle;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge clk);
  endtask : settle
  task automatic hold_reset;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : hold_reset
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    wrap_up;
  end
  initial begin
    rst = 1'b1;
    bws = 1'b0;
    @(posedge clk);
    hold_reset;
    foreach (rows[i]) begin
      bws <= rows[i].bws;
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a, rows[i].d);
    end
    fcs_host_model_inst.prog(32'h8014, 32'h1234abcd);
    settle;
    rd(32'h880, 32'h1);
    rd(32'h8014, 32'h1234abcd);
    fcs_host_model_inst.cmd2(32'h8000, 32'h25, 32'h801c, 32'hd0);
    stat(32'ha0);
    wr(32'h8000, 32'h50);
    stat(32'h80);
    fcs_host_model_inst.cmd2(32'h8000, 32'h20, 32'h801c, 32'hd0);
    settle;
    rd(32'h8014, 32'hffffffff);
    fcs_host_model_inst.cmd2(32'h8000, 32'h71, 32'h800c, 32'hd0);
    stat(32'hc0);
    fcs_host_model_inst.cmd2(32'h8000, 32'h71, 32'h801c, 32'hd0);
    stat(32'h80);
    fcs_host_model_inst.cmd2(32'h8000, 32'h20, 32'h8014, 32'hd0);
    stat(32'hb0);
    rd(32'h8000, 32'hffffffff);
    hold_reset;
    rd(32'h884, 32'h0);
    rd(32'h8c0, 32'h0);
    wrap_up;
  end
endmodule : flash_command_sequencer_bench
